//--- src/pmbus_fault_pkg.sv
// Package with command codes, field layouts and carriers of the fault-status bank.
package pmbus_fault_pkg;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [7:0] CMD_TURN_OFF_FALL_TIME    = 8'h65;
	localparam logic [7:0] CMD_FAULT_SUMMARY_BYTE    = 8'h78;
	localparam logic [7:0] CMD_FAULT_SUMMARY_WORD    = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
	localparam logic [7:0] CMD_DRIVER_SUPPLY_STATUS  = 8'h7c;
	localparam logic [7:0] CMD_TEMPERATURE_STATUS    = 8'h7d;
	localparam logic [7:0] CMD_COMM_MEMORY_LOGIC     = 8'h7e;
	localparam logic [7:0] CMD_INPUT_STATUS          = 8'h80;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [15:0] FALL_TIME_RESET   = 16'h0005;
	localparam int          FALL_TIME_DEF_MS  = 5;
	localparam int          FALL_TIME_MAX_MS  = 200;
	localparam logic [7:0]  STATUS_RESET      = 8'h00;
	localparam logic [15:0] SUMMARY_RESET     = 16'h0000;
	localparam int          L11_EXP_MSB       = 15;
	localparam int          L11_EXP_LSB       = 11;
	localparam int          L11_MANT_MSB      = 10;

	// ****************************************************************
	// Detail register indices
	// ****************************************************************
	localparam int DET_VOUT  = 0;
	localparam int DET_IOUT  = 1;
	localparam int DET_DRV   = 2;
	localparam int DET_TEMP  = 3;
	localparam int DET_CML   = 4;
	localparam int DET_VIN   = 5;
	localparam int DET_MISC  = 6;
	localparam int NUM_DET   = 7;

	// ****************************************************************
	// Summary and comm detail bit positions
	// ****************************************************************
	localparam int SB_BUSY = 7;
	localparam int SB_OFF  = 6;
	localparam int SB_VOV  = 5;
	localparam int SB_IOC  = 4;
	localparam int SB_DUV  = 3;
	localparam int SB_TEMP = 2;
	localparam int SB_CML  = 1;
	localparam int SB_NOTA = 0;
	localparam int SW_VOUT = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_DRV  = 13;
	localparam int SW_VIN  = 12;
	localparam int SW_PGN  = 11;
	localparam int SW_FAN  = 10;
	localparam int SW_OTH  = 9;
	localparam int SW_UNK  = 8;
	localparam int CML_BAD_CMD  = 7;
	localparam int CML_BAD_DATA = 6;
	localparam int CML_PACKET   = 5;
	localparam int CML_RO_WRITE = 1;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  code;
		logic [15:0] wdata;
	} cmd_req_s;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [15:0] data;
	} rsp_s;

	// Each 4-bit group is {ov fault, ov warning, uv warning, uv fault} or alike.
	typedef struct packed {
		logic [3:0] vout;
		logic [3:0] iout;
		logic [3:0] drv;
		logic [3:0] temp;
		logic [4:0] vin;
		logic       busy;
		logic       fan;
		logic       other;
		logic       unknown;
		logic       invalid_data;
		logic       packet_err;
	} fault_evt_s;

endpackage

//--- src/pmbus_fault_status_bank.sv
// Fault-status register bank with turn-off fall-time setting.
`timescale 1ns/1ps

// Behaviour
// - Two-byte RW fall time, linear-eleven format, default 5 ms, range 0 to 200 ms.
// - Read-only summary byte at 78h, reads 00h after reset.
// - Summary bit 7 set when a busy fault is declared.
// - Summary bit 6 high whenever the output is not powered.
// - Summary bits 5, 4, 3: output overvoltage, overcurrent, driver supply undervoltage.
// - Summary bit 2 any temperature event, bit 1 any comm fault.
// - Summary bit 0 for any event not covered by bits 7 to 1.
// - Read-only summary word at 79h, low byte same storage as summary byte.
// - Word bits 15 to 12: output voltage, current, driver supply, input.
// - Word bit 11 set while power good is deasserted.
// - Word bit 10 fan events, bit 9 other status events.
// - Word bit 8 for fault types no other word bit describes.
// - Output voltage status byte at 7Ah, fault and warning bits 7 to 4.
// - Output current status byte at 7Bh, fault and warning bits 7 to 4.
// - Driver supply status byte at 7Ch, fault and warning bits 7 to 4.
// - Temperature status byte at 7Dh, fault and warning bits 7 to 4.
// - Comm, memory and logic error byte at 7Eh feeds the comm summary bit.
// - Input status byte at 80h feeds the input summary bit.
module pmbus_fault_status_bank
	import pmbus_fault_pkg::*;
#(
	parameter int FALL_MAX_MS = FALL_TIME_MAX_MS
)
(
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire cmd_req_s    i_cmd,
	input  wire fault_evt_s  i_evt,
	input  wire logic        i_output_on,
	input  wire logic        i_power_good,
	input  wire logic        i_clear_faults,
	output rsp_s             o_rsp,
	output logic [15:0]      o_turn_off_fall_time,
	output logic [15:0]      o_fault_summary_word
);

	// ****************************************************************
	// Command decode
	// ****************************************************************
	wire logic        is_fall;
	wire logic        is_byte;
	wire logic        is_word;
	wire logic        is_detail;
	wire logic        known;
	wire logic        bad_code;
	wire logic        ro_write;
	wire logic        bad_data;
	wire logic        fall_ok;
	wire logic        fall_write;
	wire logic [4:0]  fall_exp;
	wire logic [4:0]  fall_mag;
	wire logic [31:0] fall_mant;
	wire logic [31:0] fall_lhs;
	wire logic [31:0] fall_rhs;

	assign is_fall   = i_cmd.code == CMD_TURN_OFF_FALL_TIME;
	assign is_byte   = i_cmd.code == CMD_FAULT_SUMMARY_BYTE;
	assign is_word   = i_cmd.code == CMD_FAULT_SUMMARY_WORD;
	assign is_detail = (i_cmd.code >= CMD_OUTPUT_VOLTAGE_STATUS
	                    && i_cmd.code <= CMD_COMM_MEMORY_LOGIC)
	                   || i_cmd.code == CMD_INPUT_STATUS;
	assign known     = is_fall | is_byte | is_word | is_detail;
	assign bad_code  = i_cmd.valid & ~known;
	assign ro_write  = i_cmd.valid & i_cmd.write & known & ~is_fall;

	// The fall time is checked as a real value in ms; a negative
	// exponent scales the limit up instead of dropping fraction bits.
	assign fall_exp  = i_cmd.wdata[L11_EXP_MSB:L11_EXP_LSB];
	assign fall_mag  = fall_exp[4] ? 5'(-fall_exp) : fall_exp;
	assign fall_mant = {21'h000000, i_cmd.wdata[L11_MANT_MSB:0]};
	assign fall_lhs  = fall_exp[4] ? fall_mant : (fall_mant << fall_mag);
	assign fall_rhs  = fall_exp[4] ? (32'(FALL_MAX_MS) << fall_mag) : 32'(FALL_MAX_MS);
	assign fall_ok   = ~i_cmd.wdata[L11_MANT_MSB] && fall_lhs <= fall_rhs;
	assign fall_write = i_cmd.valid & i_cmd.write & is_fall & fall_ok;
	assign bad_data  = i_cmd.valid & i_cmd.write & is_fall & ~fall_ok;

	// ****************************************************************
	// Fall time setting
	// ****************************************************************
	logic [15:0] fall_q;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			fall_q <= FALL_TIME_RESET;
		else if (fall_write)
			fall_q <= i_cmd.wdata;
	end

	assign o_turn_off_fall_time = fall_q;

	// ****************************************************************
	// Sticky detail registers
	// ****************************************************************
	logic [7:0] det_set [NUM_DET];
	logic [7:0] detail_q [NUM_DET];

	assign det_set[DET_VOUT] = {i_evt.vout, 4'h0};
	assign det_set[DET_IOUT] = {i_evt.iout, 4'h0};
	assign det_set[DET_DRV]  = {i_evt.drv, 4'h0};
	assign det_set[DET_TEMP] = {i_evt.temp, 4'h0};
	assign det_set[DET_CML]  = {bad_code, bad_data | i_evt.invalid_data, i_evt.packet_err,
	                            3'h0, ro_write, 1'h0};
	assign det_set[DET_VIN]  = {2'h0, i_evt.vin[4:2], 1'h0, i_evt.vin[1:0]};
	assign det_set[DET_MISC] = {4'h0, i_evt.busy, i_evt.fan, i_evt.other, i_evt.unknown};

	// An event in the cycle of a clear survives it, so no fault is lost.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_DET; gi++)
		begin : g_detail
			always_ff @(posedge i_clk or negedge i_arst_n)
			begin
				if (!i_arst_n)
					detail_q[gi] <= STATUS_RESET;
				else
					detail_q[gi] <= (detail_q[gi] & {8{~i_clear_faults}}) | det_set[gi];
			end
		end
	endgenerate

	// ****************************************************************
	// Summary word
	// ****************************************************************
	wire logic        misc_busy;
	wire logic        misc_fan;
	wire logic        misc_other;
	wire logic        misc_unknown;
	wire logic [15:0] summary_d;
	logic      [15:0] summary_q;

	assign misc_busy    = detail_q[DET_MISC][3];
	assign misc_fan     = detail_q[DET_MISC][2];
	assign misc_other   = detail_q[DET_MISC][1];
	assign misc_unknown = detail_q[DET_MISC][0];

	assign summary_d[SB_BUSY] = misc_busy;
	assign summary_d[SB_OFF]  = ~i_output_on;
	assign summary_d[SB_VOV]  = detail_q[DET_VOUT][7];
	assign summary_d[SB_IOC]  = detail_q[DET_IOUT][7];
	assign summary_d[SB_DUV]  = detail_q[DET_DRV][4];
	assign summary_d[SB_TEMP] = |detail_q[DET_TEMP];
	assign summary_d[SB_CML]  = |detail_q[DET_CML];
	assign summary_d[SB_NOTA] = |detail_q[DET_VOUT][6:4] | |detail_q[DET_IOUT][6:4]
	                          | |detail_q[DET_DRV][7:5] | |detail_q[DET_VIN]
	                          | misc_fan | misc_other | misc_unknown;
	assign summary_d[SW_VOUT] = |detail_q[DET_VOUT];
	assign summary_d[SW_IOUT] = |detail_q[DET_IOUT];
	assign summary_d[SW_DRV]  = |detail_q[DET_DRV];
	assign summary_d[SW_VIN]  = |detail_q[DET_VIN];
	assign summary_d[SW_PGN]  = ~i_power_good;
	assign summary_d[SW_FAN]  = misc_fan;
	assign summary_d[SW_OTH]  = misc_other;
	assign summary_d[SW_UNK]  = misc_unknown;

	// One register serves both views, so byte and word can never disagree.
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			summary_q <= SUMMARY_RESET;
		else
			summary_q <= summary_d;
	end

	assign o_fault_summary_word = summary_q;

	// ****************************************************************
	// Read path and response
	// ****************************************************************
	logic [15:0] rd_data;

	always_comb
	begin
		rd_data = 16'h0000;
		case (i_cmd.code)
			CMD_TURN_OFF_FALL_TIME:    rd_data = fall_q;
			CMD_FAULT_SUMMARY_BYTE:    rd_data = {8'h00, summary_q[7:0]};
			CMD_FAULT_SUMMARY_WORD:    rd_data = summary_q;
			CMD_OUTPUT_VOLTAGE_STATUS: rd_data = {8'h00, detail_q[DET_VOUT]};
			CMD_OUTPUT_CURRENT_STATUS: rd_data = {8'h00, detail_q[DET_IOUT]};
			CMD_DRIVER_SUPPLY_STATUS:  rd_data = {8'h00, detail_q[DET_DRV]};
			CMD_TEMPERATURE_STATUS:    rd_data = {8'h00, detail_q[DET_TEMP]};
			CMD_COMM_MEMORY_LOGIC:     rd_data = {8'h00, detail_q[DET_CML]};
			CMD_INPUT_STATUS:          rd_data = {8'h00, detail_q[DET_VIN]};
			default:                   rd_data = 16'h0000;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_rsp <= '0;
		else
		begin
			o_rsp.valid <= i_cmd.valid;
			o_rsp.err   <= bad_code | ro_write | bad_data;
			o_rsp.data  <= (i_cmd.valid && !i_cmd.write) ? rd_data : 16'h0000;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	AST_FALL_WRITE: assert property (
		fall_write |=> o_turn_off_fall_time == $past(i_cmd.wdata))
		else $error("fall time write not stored");

	AST_FALL_REJECT: assert property (
		bad_data |=> $stable(o_turn_off_fall_time) && o_rsp.err ##1 detail_q[DET_CML][6])
		else $error("out of range fall time not rejected");

	AST_BYTE_READ: assert property (
		i_cmd.valid && !i_cmd.write && is_byte
		|=> o_rsp.valid && o_rsp.data == {8'h00, $past(summary_q[7:0])})
		else $error("summary byte read wrong");

	AST_BUSY_SETS: assert property (
		i_evt.busy |-> ##2 o_fault_summary_word[SB_BUSY])
		else $error("busy event missed in summary");

	AST_OFF_LEVEL: assert property (
		!i_output_on |=> o_fault_summary_word[SB_OFF])
		else $error("off bit not shown");

	AST_OV_SETS: assert property (
		i_evt.vout[3] |=> detail_q[DET_VOUT][7] ##1 o_fault_summary_word[SB_VOV]
		                  && o_fault_summary_word[SW_VOUT])
		else $error("overvoltage not reported");

	AST_TEMP_SETS: assert property (
		|i_evt.temp |-> ##2 o_fault_summary_word[SB_TEMP])
		else $error("temperature event missed");

	AST_WORD_LOW_SAME: assert property (
		i_cmd.valid && !i_cmd.write && is_word
		|=> o_rsp.data[7:0] == $past(summary_q[7:0]))
		else $error("word low byte differs from summary byte");

	AST_PG_LEVEL: assert property (
		!i_power_good |=> o_fault_summary_word[SW_PGN])
		else $error("power good loss not shown");

	AST_CURRENT_AGREE: assert property (
		o_fault_summary_word[SW_IOUT] == $past(|detail_q[DET_IOUT]))
		else $error("current summary disagrees with detail");

	AST_RO_WRITE: assert property (
		ro_write |=> o_rsp.err && detail_q[DET_CML][CML_RO_WRITE]
		         ##1 o_fault_summary_word[SB_CML])
		else $error("read-only write not flagged");

	AST_CLEAR_KEEPS_EVENT: assert property (
		i_clear_faults && i_evt.vout[0] |=> detail_q[DET_VOUT][4])
		else $error("event lost on clear");

	// ****************************************************************
	// Event, read and answer paths
	// ****************************************************************
	// An event needs two edges to show in the summary: one into the
	// detail byte and one into the shared summary register.

	AST_IOC_SETS: assert property (
		i_evt.iout[3] |-> ##2 o_fault_summary_word[SB_IOC] && o_fault_summary_word[SW_IOUT])
		else $error("overcurrent not reported");

	AST_DUV_SETS: assert property (
		i_evt.drv[0] |-> ##2 o_fault_summary_word[SB_DUV])
		else $error("driver supply undervoltage not reported");

	AST_CML_SETS: assert property (
		i_evt.packet_err |-> ##2 o_fault_summary_word[SB_CML])
		else $error("comm fault missed in summary");

	AST_NOTA_FAN: assert property (
		i_evt.fan |-> ##2 o_fault_summary_word[SB_NOTA] && o_fault_summary_word[SW_FAN])
		else $error("fan event missed in summary");

	AST_VIN_SETS: assert property (
		|i_evt.vin |-> ##2 o_fault_summary_word[SW_VIN] && o_fault_summary_word[SB_NOTA])
		else $error("input event missed in summary");

	AST_OTHER_SETS: assert property (
		i_evt.other |-> ##2 o_fault_summary_word[SW_OTH])
		else $error("other event missed in summary");

	AST_UNKNOWN_SETS: assert property (
		i_evt.unknown |-> ##2 o_fault_summary_word[SW_UNK])
		else $error("unknown event missed in summary");

	AST_IOUT_DETAIL: assert property (
		i_evt.iout[2] |=> detail_q[DET_IOUT][6])
		else $error("current detail bit not set");

	AST_DRV_DETAIL: assert property (
		i_evt.drv[3] |=> detail_q[DET_DRV][7] ##1 o_fault_summary_word[SW_DRV])
		else $error("driver supply detail not set");

	AST_TEMP_DETAIL: assert property (
		i_evt.temp[0] |=> detail_q[DET_TEMP][4])
		else $error("temperature detail bit not set");

	AST_BAD_CODE: assert property (
		bad_code |=> o_rsp.err && o_rsp.data == '0 && detail_q[DET_CML][CML_BAD_CMD])
		else $error("unknown code not flagged");

	AST_RSP_ONE: assert property (
		o_rsp.valid == $past(i_cmd.valid))
		else $error("answer not one cycle after request");

	AST_RO_KEEPS: assert property (
		ro_write |=> $stable(o_turn_off_fall_time))
		else $error("read-only write changed setting");

	AST_WRITE_NO_DATA: assert property (
		i_cmd.valid && i_cmd.write |=> o_rsp.data == '0)
		else $error("write answer carries data");

	AST_WORD_READ: assert property (
		i_cmd.valid && !i_cmd.write && is_word |=> o_rsp.data == $past(summary_q))
		else $error("summary word read wrong");

	AST_DETAIL_READ: assert property (
		i_cmd.valid && !i_cmd.write && i_cmd.code == CMD_OUTPUT_VOLTAGE_STATUS
		|=> o_rsp.data == {8'h00, $past(detail_q[DET_VOUT])})
		else $error("voltage detail read wrong");

	AST_FALL_READ: assert property (
		i_cmd.valid && !i_cmd.write && is_fall |=> o_rsp.data == $past(fall_q))
		else $error("fall time read wrong");

	COV_WORD_READ: cover property (i_cmd.valid && !i_cmd.write && is_word ##1 o_rsp.valid);
	COV_BUSY:     cover property (i_evt.busy ##2 o_fault_summary_word[SB_BUSY]);
	COV_RO_WRITE: cover property (ro_write ##1 o_rsp.err);
	COV_FALL:     cover property (fall_write ##1 o_rsp.valid);
	COV_CLEAR:    cover property (|detail_q[DET_TEMP] ##1 i_clear_faults
	                              ##1 detail_q[DET_TEMP] == STATUS_RESET);

endmodule

//--- tb/pmbus_host_model.sv
// Bus host model that issues one command at a time and collects its answer.
`timescale 1ns/1ps
module pmbus_host_model
	import pmbus_fault_pkg::*;
(
	input  wire logic     i_clk,
	input  wire rsp_s     i_rsp,
	output cmd_req_s      o_cmd
);
	initial o_cmd = '0;

	// The answer is taken just after the edge that loads it; the request
	// fields are inverted once released so stale values are never reused.
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output rsp_s r);
		@(posedge i_clk);
		o_cmd <= {1'b1, w, c, d};
		@(posedge i_clk);
		o_cmd <= {1'b0, ~w, ~c, ~d};
		#1;
		r = i_rsp;
	endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the fault-status bank with a behavioural model.
`timescale 1ns/1ps
module tb_top;
	import pmbus_fault_pkg::*;
	// ****************************************************************
	// Signals and model state
	// ****************************************************************
	logic        clk;
	logic        arst_n;
	cmd_req_s    cmd;
	fault_evt_s  evt;
	logic        out_on;
	logic        pgood;
	logic        clr;
	rsp_s        rsp;
	logic [15:0] fall;
	logic [15:0] sword;
	logic [7:0]  det [NUM_DET];
	logic [15:0] m_fall;
	logic [7:0]  codes [9] = '{8'h65, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
	logic [15:0] falls [6] = '{16'h00c8, 16'h00c9, 16'h0864, 16'h0400, 16'hf990, 16'h0000};
	int          errors = 0;
	int          total_checks = 0;
	int          seed = 10;
	int          cyc = 0;

	pmbus_fault_status_bank pmbus_fault_status_bank_i (.i_clk(clk), .i_arst_n(arst_n),
		.i_cmd(cmd), .i_evt(evt), .i_output_on(out_on), .i_power_good(pgood),
		.i_clear_faults(clr), .o_rsp(rsp), .o_turn_off_fall_time(fall),
		.o_fault_summary_word(sword));
	pmbus_host_model pmbus_host_model_i (.i_clk(clk), .i_rsp(rsp), .o_cmd(cmd));

	always #4 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			$display("wrong value at %0t: run did not finish", $time);
			print_verdict();
		end
	end

	// ****************************************************************
	// Model and checks
	// ****************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [15:0] m_sum();
		logic [7:0] m;
		m = det[DET_MISC];
		m_sum = {|det[DET_VOUT], |det[DET_IOUT], |det[DET_DRV], |det[DET_VIN], ~pgood, m[2],
			m[1], m[0], m[3], ~out_on, det[DET_VOUT][7], det[DET_IOUT][7], det[DET_DRV][4],
			|det[DET_TEMP], |det[DET_CML], |det[DET_VOUT][6:4] | |det[DET_IOUT][6:4]
			| |det[DET_DRV][7:5] | |det[DET_VIN] | |m[2:0]};
	endfunction

	function automatic logic [15:0] m_read(input logic [7:0] c);
		if (c == CMD_TURN_OFF_FALL_TIME) return m_fall;
		if (c == CMD_FAULT_SUMMARY_BYTE) return m_sum() & 16'h00ff;
		if (c == CMD_FAULT_SUMMARY_WORD) return m_sum();
		if (c inside {[8'h7a:8'h7e]}) return {8'h00, det[c - 8'h7a]};
		if (c == CMD_INPUT_STATUS) return {8'h00, det[DET_VIN]};
		return 16'h0000;
	endfunction

	// Exact value check in real ms, fraction bits kept; a negative mantissa is never a legal time.
	function automatic logic fall_ok(input logic [15:0] d);
		int e;
		int m;
		e = $signed(d[15:11]);
		m = d[10:0];
		if (d[10]) return 1'b0;
		if (e >= 0) return (m << e) <= FALL_TIME_MAX_MS;
		return m <= (FALL_TIME_MAX_MS << -e);
	endfunction

	task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
		rsp_s       r;
		logic       err;
		logic [15:0] exp;
		err = 1'b0;
		exp = w ? 16'h0000 : m_read(c);
		pmbus_host_model_i.xfer(w, c, d, r);
		if (!(c inside {8'h65, [8'h78:8'h7e], 8'h80}))
		begin
			err = 1'b1;
			det[DET_CML][CML_BAD_CMD] = 1'b1;
		end
		else if (w && c != CMD_TURN_OFF_FALL_TIME)
		begin
			err = 1'b1;
			det[DET_CML][CML_RO_WRITE] = 1'b1;
		end
		else if (w && fall_ok(d))
			m_fall = d;
		else if (w)
		begin
			err = 1'b1;
			det[DET_CML][CML_BAD_DATA] = 1'b1;
		end
		chk({14'h0, r.valid, r.err}, {14'h0, 1'b1, err}, "answer flags");
		chk(r.data, exp, "read data");
		repeat (3) @(posedge clk);
	endtask

	task automatic check_all();
		repeat (3) @(posedge clk);
		chk(sword, m_sum(), "summary word");
		chk(fall, m_fall, "fall time");
		foreach (codes[i]) send(1'b0, codes[i], 16'h0000);
	endtask

	task automatic pulse(input fault_evt_s e);
		@(posedge clk);
		evt <= e;
		out_on <= 1'($random(seed));
		pgood <= 1'($random(seed));
		@(posedge clk);
		evt <= '0;
		det[DET_VOUT] |= {e.vout, 4'h0};
		det[DET_IOUT] |= {e.iout, 4'h0};
		det[DET_DRV] |= {e.drv, 4'h0};
		det[DET_TEMP] |= {e.temp, 4'h0};
		det[DET_CML] |= {1'b0, e.invalid_data, e.packet_err, 5'h00};
		det[DET_VIN] |= {2'b00, e.vin[4:2], 1'b0, e.vin[1:0]};
		det[DET_MISC] |= {4'h0, e.busy, e.fan, e.other, e.unknown};
	endtask

	task automatic clear();
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		foreach (det[i]) det[i] = 8'h00;
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		evt = '0;
		out_on = 1'b0;
		pgood = 1'b0;
		clr = 1'b0;
		m_fall = FALL_TIME_RESET;
		foreach (det[i]) det[i] = 8'h00;
		repeat (6) @(posedge clk);
		chk(fall, FALL_TIME_RESET, "fall time reset");
		chk(sword, SUMMARY_RESET, "summary reset");
		arst_n <= 1'b1;
		check_all();
		$display("test reset done");
		for (int i = 0; i < 27; i++)
		begin
			pulse(fault_evt_s'(27'h1 << i));
			check_all();
			clear();
		end
		$display("test single events done");
		repeat (15) pulse(fault_evt_s'($random(seed)));
		check_all();
		$display("test random events done");
		@(posedge clk);
		evt <= '{vout: 4'h1, default: '0};
		clr <= 1'b1;
		@(posedge clk);
		evt <= '0;
		clr <= 1'b0;
		foreach (det[i]) det[i] = 8'h00;
		det[DET_VOUT][4] = 1'b1;
		check_all();
		clear();
		$display("test clear with event done");
		foreach (falls[i]) send(1'b1, CMD_TURN_OFF_FALL_TIME, falls[i]);
		foreach (codes[i]) send(1'b1, codes[i], 16'hffff);
		send(1'b0, 8'h81, 16'h0000);
		send(1'b1, 8'h00, 16'h1234);
		check_all();
		$display("test commands done");
		print_verdict();
	end
endmodule
